// ===== rtl/sff_map.svh
// constants for the serial flash command front end
`ifndef SFF_MAP_SVH
`define SFF_MAP_SVH

// opcodes
`define SFF_OP_SET_LATCH 8'h06
`define SFF_OP_CLEAR_LATCH 8'h04
`define SFF_OP_READ_STATUS 8'h05
`define SFF_OP_WRITE_STATUS 8'h01
`define SFF_OP_READ_ARRAY 8'h03
`define SFF_OP_PAGE_PROGRAM 8'h02
`define SFF_OP_SECTOR_ERASE 8'hD8
`define SFF_OP_BULK_ERASE 8'hC7
`define SFF_OP_DEEP_SLEEP 8'hB9
`define SFF_OP_WAKE_SIGNATURE 8'hAB

// status word bit positions
`define SFF_ST_BUSY 0
`define SFF_ST_LATCH 1
`define SFF_ST_PROT_LO 2
`define SFF_ST_PROT_HI 3
`define SFF_ST_LOCK 7

// reset values of status bits
`define SFF_RST_LOCK 1'h0
`define SFF_RST_PROT 2'h0

// geometry
`define SFF_ARRAY_BYTES 131072
`define SFF_SECTOR_BYTES 32768
`define SFF_PAGE_COUNT 1024
`define SFF_PAGE_BYTES 128
`define SFF_ADDR_W 17
`define SFF_SECTOR_LSB 15

// frame byte counts
`define SFF_BITS_PER_BYTE 8
`define SFF_ADDR_BYTES 3
`define SFF_FIFO_DEPTH 8

`endif

// ===== rtl/sff_pkg.sv
// types for the serial flash command front end
package sff_pkg;

    typedef enum logic [2:0] {
        SFF_OP_NONE,
        SFF_OP_STATUS_WRITE,
        SFF_OP_PROGRAM,
        SFF_OP_ERASE_SECTOR,
        SFF_OP_ERASE_ALL,
        SFF_OP_READ
    } sff_op_kind_t;

    typedef struct packed {
        sff_op_kind_t kind;
        logic [16:0] addr;
        logic [1:0] sector;
        logic [7:0] status_data;
    } sff_op_req_t;

    typedef struct packed {
        logic lock;
        logic [2:0] zero;
        logic prot_hi;
        logic prot_lo;
        logic latch;
        logic busy;
    } sff_status_t;

endpackage

// ===== rtl/sff_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
module sff_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic flush,
    // fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign in_ready = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data = mem_r[rd_ptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else if (flush) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule

// ===== rtl/sff_front_end.sv
// serial flash command front end: opcode decode, status word, write checks
// Functional notes
// [RQ1] all bytes move most significant bit first
// [RQ2] opcode is first eight bits after select falls
// [RQ3] decode set latch, clear latch, read status
// [RQ4] decode status write, array read, page program
// [RQ5] sector erase and bulk erase opcodes
// [RQ6] decode deep sleep and wake with signature
// [RQ7] array geometry: four sectors, 1024 pages
// [RQ8] address bits 16:15 select the sector
// [RQ9] program only clears bits, per page
// [RQ10] writing commands need byte-aligned select rise
// [RQ11] master raises select after last bit
// [RQ12] array access ignored while busy
// [RQ13] set/clear latch framed as bare opcode
// [RQ14] master sets latch before each write
// [RQ15] latch clears at reset and write completion
// [RQ16] status readable anytime, repeats while clocked
// [RQ17] master should poll busy before new commands
// [RQ18] busy high during write cycles, self-managed
// [RQ19] latch clear blocks all write commands
// [RQ20] protect bits written unless hardware locked
// [RQ21] bulk erase only with protect bits zero
// [RQ22] lock bit plus protect pin low locks status
// [RQ23] protect code selects protected sectors
// [RQ24] bits 6:4 read zero, write keeps 6,5,4,1,0
// [RQ25] deep sleep ignores all but wake
// [RQ26] status layout: busy0 latch1 prot2,3 lock7
`timescale 1ns/1ns
`include "sff_map.svh"
module sff_front_end #(
    parameter logic [7:0] SIGNATURE = 8'h5A, // arbitrary value
    parameter int FIFO_DEPTH = `SFF_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // serial link pins
    input wire logic device_select_n,
    input wire logic serial_clock_in,
    input wire logic serial_in,
    input wire logic write_protect_n,
    output logic serial_out,
    output logic serial_out_en,
    // array engine requests
    output logic op_start,
    output sff_pkg::sff_op_req_t op_req,
    input wire logic op_done,
    // array read bytes
    output logic rd_byte_req,
    input wire logic [7:0] rd_byte,
    // program data stream
    output logic prog_valid,
    output logic [7:0] prog_data,
    input wire logic prog_ready,
    // state
    output logic [7:0] status_word,
    output logic deep_sleep
);
    // pin synchronisers
    logic [1:0] cs_sync_r;
    logic [1:0] sck_sync_r;
    logic [1:0] sin_sync_r;
    logic [1:0] wp_sync_r;
    logic cs_prev_r;
    logic sck_prev_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cs_sync_r <= 2'h3;
            sck_sync_r <= 2'h0;
            sin_sync_r <= 2'h0;
            wp_sync_r <= 2'h3;
            cs_prev_r <= 1'b1;
            sck_prev_r <= 1'b0;
        end else begin
            cs_sync_r <= {cs_sync_r[0], device_select_n};
            sck_sync_r <= {sck_sync_r[0], serial_clock_in};
            sin_sync_r <= {sin_sync_r[0], serial_in};
            wp_sync_r <= {wp_sync_r[0], write_protect_n};
            cs_prev_r <= cs_sync_r[1];
            sck_prev_r <= sck_sync_r[1];
        end
    end

    logic selected;
    logic sck_rise;
    logic sck_fall;
    logic frame_end;
    assign selected = !cs_sync_r[1];
    assign sck_rise = selected && sck_sync_r[1] && !sck_prev_r; // see [RQ2]
    assign sck_fall = selected && !sck_sync_r[1] && sck_prev_r;
    assign frame_end = cs_sync_r[1] && !cs_prev_r;

    // status bits
    logic busy_r;
    logic latch_r;
    logic [1:0] prot_r;
    logic lock_r;
    logic sleep_r;
    logic hw_lock;
    sff_pkg::sff_status_t status;
    assign hw_lock = lock_r && !wp_sync_r[1]; // see [RQ22]
    always_comb begin
        status = '0; // see [RQ24]
        status.busy = busy_r;
        status.latch = latch_r;
        status.prot_lo = prot_r[0];
        status.prot_hi = prot_r[1];
        status.lock = lock_r;
    end

    function automatic logic sector_protected(input logic [1:0] sector, input logic [1:0] prot);
        unique case (prot)
            2'h0: sector_protected = 1'b0;
            2'h1: sector_protected = (sector == 2'h3);
            2'h2: sector_protected = sector[1];
            2'h3: sector_protected = 1'b1;
        endcase
    endfunction // see [RQ23]

    // bit and byte counters, input shifter
    logic [2:0] bit_cnt_r;
    logic [2:0] byte_idx_r;
    logic [7:0] in_shift_r;
    logic [7:0] in_byte;
    logic byte_done;
    assign in_byte = {in_shift_r[6:0], sin_sync_r[1]}; // see [RQ1]
    assign byte_done = sck_rise && (bit_cnt_r == 3'h7);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_cnt_r <= 3'h0;
            byte_idx_r <= 3'h0;
            in_shift_r <= 8'h00;
        end else if (!selected) begin
            bit_cnt_r <= 3'h0;
            byte_idx_r <= 3'h0;
        end else if (sck_rise) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            in_shift_r <= in_byte;
            if (byte_done && byte_idx_r != 3'h7) begin
                byte_idx_r <= byte_idx_r + 3'h1;
            end
        end
    end

    // opcode, address and data capture
    logic [7:0] opcode_r;
    logic [23:0] addr_r;
    logic [7:0] data_r;
    logic ignore_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            opcode_r <= 8'h00;
            addr_r <= 24'h0;
            data_r <= 8'h00;
            ignore_r <= 1'b0;
        end else if (frame_end) begin
            opcode_r <= 8'h00;
            ignore_r <= 1'b0;
        end else if (byte_done) begin
            if (byte_idx_r == 3'h0) begin
                opcode_r <= in_byte; // see [RQ2]
                ignore_r <= sleep_r && (in_byte != `SFF_OP_WAKE_SIGNATURE); // see [RQ25]
            end else if (byte_idx_r <= 3'(`SFF_ADDR_BYTES)) begin
                addr_r <= {addr_r[15:0], in_byte}; // see [RQ1]
            end
            if (byte_idx_r == 3'h1) begin
                data_r <= in_byte;
            end
        end
    end

    logic [16:0] addr;
    logic [1:0] sector;
    logic aligned;
    logic may_write;
    assign addr = addr_r[`SFF_ADDR_W-1:0];
    assign sector = addr_r[`SFF_ADDR_W-1:`SFF_SECTOR_LSB]; // see [RQ7] see [RQ8]
    assign aligned = (bit_cnt_r == 3'h0); // see [RQ10]
    assign may_write = !ignore_r && latch_r && !busy_r && aligned; // see [RQ19] see [RQ12]

    // program data into the fifo
    logic fifo_in_ready;
    logic push_byte;
    logic overrun_r;
    logic reject;
    assign push_byte = byte_done && !ignore_r && opcode_r == `SFF_OP_PAGE_PROGRAM
        && byte_idx_r > 3'(`SFF_ADDR_BYTES) && latch_r && !busy_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            overrun_r <= 1'b0;
        end else if (frame_end) begin
            overrun_r <= 1'b0;
        end else if (push_byte && !fifo_in_ready) begin
            overrun_r <= 1'b1;
        end
    end

    sff_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_prog_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .flush(reject),
        .in_valid(push_byte),
        .in_data(in_byte),
        .in_ready(fifo_in_ready),
        .out_valid(prog_valid),
        .out_data(prog_data),
        .out_ready(prog_ready)
    );

    // end-of-frame decision
    logic accept;
    sff_pkg::sff_op_kind_t kind;
    always_comb begin
        accept = 1'b0;
        kind = sff_pkg::SFF_OP_NONE;
        unique case (opcode_r)
            `SFF_OP_WRITE_STATUS: begin
                kind = sff_pkg::SFF_OP_STATUS_WRITE;
                accept = may_write && byte_idx_r >= 3'h2 && !hw_lock; // see [RQ22]
            end
            `SFF_OP_PAGE_PROGRAM: begin
                kind = sff_pkg::SFF_OP_PROGRAM; // see [RQ9]
                accept = may_write && byte_idx_r > 3'(`SFF_ADDR_BYTES) && !overrun_r
                    && !sector_protected(sector, prot_r); // see [RQ20]
            end
            `SFF_OP_SECTOR_ERASE: begin
                kind = sff_pkg::SFF_OP_ERASE_SECTOR; // see [RQ5]
                accept = may_write && byte_idx_r > 3'(`SFF_ADDR_BYTES)
                    && !sector_protected(sector, prot_r); // see [RQ20]
            end
            `SFF_OP_BULK_ERASE: begin
                kind = sff_pkg::SFF_OP_ERASE_ALL; // see [RQ5]
                accept = may_write && byte_idx_r >= 3'h1 && prot_r == 2'h0; // see [RQ21]
            end
            default: begin
                accept = 1'b0;
            end
        endcase
    end
    assign reject = frame_end && opcode_r == `SFF_OP_PAGE_PROGRAM && !accept;

    logic read_go;
    assign read_go = byte_done && !ignore_r && !busy_r && opcode_r == `SFF_OP_READ_ARRAY
        && byte_idx_r >= 3'(`SFF_ADDR_BYTES); // see [RQ4] see [RQ12]

    // requests to the array engine
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            op_start <= 1'b0;
            op_req <= '0;
            rd_byte_req <= 1'b0;
        end else begin
            op_start <= 1'b0;
            rd_byte_req <= read_go;
            if (frame_end && accept) begin
                op_start <= 1'b1;
                op_req.kind <= kind;
                op_req.addr <= addr;
                op_req.sector <= sector;
                op_req.status_data <= data_r;
            end else if (read_go && byte_idx_r == 3'(`SFF_ADDR_BYTES)) begin
                op_start <= 1'b1;
                op_req.kind <= sff_pkg::SFF_OP_READ;
                op_req.addr <= {addr_r[8:0], in_byte}; // see [RQ1]
                op_req.sector <= 2'h0;
                op_req.status_data <= 8'h00;
            end
        end
    end

    // busy flag
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_r <= 1'b0;
        end else if (frame_end && accept) begin
            busy_r <= 1'b1; // see [RQ18]
        end else if (op_done) begin
            busy_r <= 1'b0; // see [RQ18]
        end
    end

    // write latch
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            latch_r <= 1'b0; // see [RQ15]
        end else if (busy_r && op_done) begin
            latch_r <= 1'b0; // see [RQ15]
        end else if (frame_end && !ignore_r && byte_idx_r == 3'h1 && aligned) begin
            if (opcode_r == `SFF_OP_SET_LATCH) begin
                latch_r <= 1'b1; // see [RQ3] see [RQ13]
            end else if (opcode_r == `SFF_OP_CLEAR_LATCH) begin
                latch_r <= 1'b0; // see [RQ3] see [RQ13] see [RQ15]
            end
        end
    end

    // non-volatile bits, only 7, 3 and 2 are written
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prot_r <= `SFF_RST_PROT;
            lock_r <= `SFF_RST_LOCK;
        end else if (frame_end && accept && kind == sff_pkg::SFF_OP_STATUS_WRITE) begin
            prot_r <= {data_r[`SFF_ST_PROT_HI], data_r[`SFF_ST_PROT_LO]}; // see [RQ20] see [RQ24]
            lock_r <= data_r[`SFF_ST_LOCK]; // see [RQ26]
        end
    end

    // deep power-down
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sleep_r <= 1'b0;
        end else if (frame_end && !ignore_r && byte_idx_r >= 3'h1 && !busy_r) begin
            if (opcode_r == `SFF_OP_DEEP_SLEEP) begin
                sleep_r <= 1'b1; // see [RQ6]
            end else if (opcode_r == `SFF_OP_WAKE_SIGNATURE) begin
                sleep_r <= 1'b0; // see [RQ6] see [RQ25]
            end
        end
    end

    // serial output: loaded at byte end, shifted on falling edges
    logic [7:0] out_shift_r;
    logic out_active_r;
    logic [7:0] load_byte;
    logic load;
    always_comb begin
        load = 1'b0;
        load_byte = 8'h00;
        if (byte_done && !ignore_r) begin
            if (opcode_r == `SFF_OP_READ_STATUS
                || (byte_idx_r == 3'h0 && in_byte == `SFF_OP_READ_STATUS && !sleep_r)) begin
                load = 1'b1;
                load_byte = status; // see [RQ16] see [RQ26]
            end else if (opcode_r == `SFF_OP_WAKE_SIGNATURE
                && byte_idx_r >= 3'(`SFF_ADDR_BYTES)) begin
                load = 1'b1;
                load_byte = SIGNATURE; // see [RQ6]
            end else if (read_go) begin
                load = 1'b1;
                load_byte = rd_byte;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_shift_r <= 8'h00;
            out_active_r <= 1'b0;
            serial_out <= 1'b0;
            serial_out_en <= 1'b0;
        end else if (!selected) begin
            out_active_r <= 1'b0;
            serial_out_en <= 1'b0;
        end else begin
            if (load) begin
                out_shift_r <= load_byte;
                out_active_r <= 1'b1;
            end else if (sck_fall && out_active_r) begin
                out_shift_r <= {out_shift_r[6:0], 1'b0};
            end
            if (sck_fall && out_active_r) begin
                serial_out <= out_shift_r[7]; // see [RQ1]
                serial_out_en <= 1'b1;
            end
        end
    end

    // exported state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_word <= 8'h00;
            deep_sleep <= 1'b0;
        end else begin
            status_word <= status;
            deep_sleep <= sleep_r;
        end
    end

endmodule

// ===== test/sff_checker.sv
// port assertions for the serial flash command front end
`timescale 1ns/1ns
module sff_checker (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // pins
    input wire logic write_protect_n,
    // array engine
    input wire logic op_start,
    input wire sff_pkg::sff_op_req_t op_req,
    input wire logic op_done,
    // state
    input wire logic [7:0] status_word,
    input wire logic deep_sleep
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    logic [1:0] bp;
    logic sec_op;
    assign bp = status_word[3:2];
    assign sec_op = op_req.kind inside {sff_pkg::SFF_OP_PROGRAM, sff_pkg::SFF_OP_ERASE_SECTOR};
    sequence s_wr_start;
        op_start && op_req.kind != sff_pkg::SFF_OP_READ;
    endsequence
    sequence s_wr_end;
        op_done && status_word[0];
    endsequence
    a_start_one_pulse: assert property (op_start |=> !op_start)
        else $error("op_start longer than one cycle");
    a_busy_rises: assert property (s_wr_start |-> ##[0:2] status_word[0])
        else $error("busy not set by write start");
    a_latch_needed: assert property (s_wr_start |-> status_word[1])
        else $error("write started without latch");
    a_idle_start: assert property (op_start |-> !$past(status_word[0]))
        else $error("start while busy");
    a_done_clears: assert property (s_wr_end |-> ##[1:3] status_word[1:0] == 2'h0)
        else $error("busy or latch kept after done");
    a_bulk_open: assert property (op_start && op_req.kind == sff_pkg::SFF_OP_ERASE_ALL
        |-> bp == 2'h0)
        else $error("bulk erase with protection");
    a_sector_open: assert property (op_start && sec_op |-> !(bp == 2'h3
        || (bp == 2'h2 && op_req.sector[1]) || (bp == 2'h1 && op_req.sector == 2'h3)))
        else $error("protected sector written");
    a_sector_map: assert property (op_start && sec_op
        |-> op_req.sector == op_req.addr[16:15])
        else $error("sector decode wrong");
    a_hw_locked: assert property (op_start && op_req.kind == sff_pkg::SFF_OP_STATUS_WRITE
        |-> !(status_word[7] && !write_protect_n))
        else $error("status write in hardware lock");
    a_zero_bits: assert property (status_word[6:4] == 3'h0)
        else $error("status bits 6:4 not zero");
    a_sleep_quiet: assert property (deep_sleep |-> !op_start)
        else $error("start in deep sleep");
endmodule
bind sff_front_end sff_checker chk_u (.clk, .reset_n, .write_protect_n, .op_start, .op_req,
    .op_done, .status_word, .deep_sleep);

// ===== test/sff_master.sv
// link master model driving select, clock and data
`timescale 1ns/1ns
module sff_master (
    // clock
    input wire logic clk,
    // link pins
    output logic sel_n,
    output logic sclk,
    output logic mosi,
    input wire logic miso
);
    initial begin
        sel_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // msb first, set while low, taken on rise
    task automatic xfer(input logic [127:0] d, input int n, output logic [127:0] rx);
        rx = '0;
        wt(4);
        sel_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            wt(1);
            mosi = d[i];
            wt(3);
            sclk = 1'b1;
            wt(4);
            rx = {rx[126:0], miso};
            sclk = 1'b0;
        end
        wt(4);
        sel_n = 1'b1;
        mosi = ~mosi;
        wt(8);
    endtask
endmodule

// ===== test/tb.sv
// testbench for the serial flash command front end
`timescale 1ns/1ns
module tb;
    localparam logic [7:0] SIG = 8'h5A; // arbitrary value
    logic clk, reset_n, wp_n, op_done, prog_ready, sel_n, sclk, mosi, so, so_en;
    logic op_start, rd_req, prog_valid, sleep;
    logic [7:0] rd_byte, prog_data, status;
    logic [127:0] rx;
    sff_pkg::sff_op_req_t op_req, last_req;
    int errors = 0;
    int checked = 0;
    int starts = 0;
    int n;
    sff_front_end #(.SIGNATURE(SIG), .FIFO_DEPTH(8)) dut_u (.clk(clk), .reset_n(reset_n),
        .device_select_n(sel_n), .serial_clock_in(sclk), .serial_in(mosi),
        .write_protect_n(wp_n), .serial_out(so), .serial_out_en(so_en), .op_start(op_start),
        .op_req(op_req), .op_done(op_done), .rd_byte_req(rd_req), .rd_byte(rd_byte),
        .prog_valid(prog_valid), .prog_data(prog_data), .prog_ready(prog_ready),
        .status_word(status), .deep_sleep(sleep));
    sff_master host_u (.clk(clk), .sel_n(sel_n), .sclk(sclk), .mosi(mosi), .miso(so));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (op_start === 1'b1) begin
            starts <= starts + 1;
            last_req <= op_req;
        end
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string m);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, m, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic x(input logic [127:0] d, input int bits);
        host_u.xfer(d, bits, rx);
    endtask
    task automatic done();
        op_done = 1'b1;
        step();
        op_done = 1'b0;
        repeat (4) step();
    endtask
    task automatic t_latch();
        x(8'h06, 8);
        chk(status[1], 1'b1, "latch set");
        x({8'h05, 16'h0}, 24);
        chk(rx[15:0], 16'h0202, "status repeat");
        x(8'h04, 8);
        chk(status, 8'h00, "latch clear");
        $display("test latch done");
    endtask
    task automatic t_protect();
        n = starts;
        x(8'h06, 8);
        x(16'h019F, 16);
        chk(last_req.kind, sff_pkg::SFF_OP_STATUS_WRITE, "status write");
        x({8'h05, 8'h0}, 16);
        chk(rx[1:0], 2'h3, "busy read");
        done();
        chk(status, 8'h8C, "status written");
        x(8'h06, 8);
        x(8'hC7, 8);
        x(32'hD8000000, 32);
        wp_n = 1'b0;
        x(16'h0100, 16);
        chk(starts - n, 1, "protected refused");
        chk(status, 8'h8E, "status kept");
        wp_n = 1'b1;
        x(16'h0104, 16);
        done();
        x(8'h06, 8);
        x(40'h0201800055, 40);
        chk(prog_valid, 1'b0, "rejected flushed");
        x({32'h02010000, 64'hA0A1A2A3A4A5A6A7}, 96);
        chk(starts - n, 3, "sector 2 open");
        chk(last_req.sector, 2'h2, "program sector");
        prog_ready = 1'b1;
        for (int i = 0; i < 8; i++) begin
            chk({prog_valid, prog_data}, {1'b1, 8'hA0 + 8'(i)}, "fifo out");
            step();
        end
        prog_ready = 1'b0;
        chk(prog_valid, 1'b0, "fifo empty");
        done();
        x(8'h06, 8);
        x(16'h0100, 16);
        done();
        chk(status, 8'h00, "unprotected");
        $display("test protect done");
    endtask
    task automatic t_align();
        n = starts;
        x(8'h06, 8);
        x({32'hD8008000, 1'b0}, 33);
        chk(starts - n, 0, "unaligned");
        x(32'hD8008000, 32);
        chk(last_req.kind, sff_pkg::SFF_OP_ERASE_SECTOR, "sector erase");
        chk(last_req.sector, 2'h1, "erase sector");
        done();
        x(8'hC7, 8);
        chk(starts - n, 1, "no latch");
        x(8'h06, 8);
        x(8'hC7, 8);
        chk(last_req.kind, sff_pkg::SFF_OP_ERASE_ALL, "bulk erase");
        x({32'h03000100, 8'h0}, 40);
        chk(starts - n, 2, "read while busy");
        done();
        chk(status, 8'h00, "busy over");
        $display("test align done");
    endtask
    task automatic t_sleep_read();
        x(8'hB9, 8);
        chk(sleep, 1'b1, "sleep");
        x(8'h06, 8);
        chk(status[1], 1'b0, "ignored asleep");
        x({8'hAB, 32'h0}, 40);
        chk({sleep, rx[7:0]}, {1'b0, SIG}, "wake");
        n = starts;
        x({8'h03, 24'h000100, 16'h0}, 48);
        chk(rx[15:0], 16'hC3C3, "read data");
        chk(last_req.kind, sff_pkg::SFF_OP_READ, "read kind");
        chk(last_req.addr, 17'h00100, "read addr");
        $display("test sleep read done");
    endtask
    initial begin
        reset_n = 1'b0;
        wp_n = 1'b1;
        op_done = 1'b0;
        prog_ready = 1'b0;
        rd_byte = 8'hC3;
        repeat (16) @(posedge clk);
        #1;
        reset_n = 1'b1;
        repeat (4) step();
        chk({sleep, so_en, status}, 10'h000, "reset state");
        t_latch();
        t_protect();
        t_align();
        t_sleep_read();
        wrap_up();
    end
    initial begin
        #3000000;
        errors++;
        wrap_up();
    end
endmodule
